// file: verilog/frac_pll_reconfig_defines.svh
// register offsets, field positions and reset values of the pll register bank
// assumes byte-addressed configuration port with 8-bit data
`ifndef FRAC_PLL_RECONFIG_DEFINES_SVH
`define FRAC_PLL_RECONFIG_DEFINES_SVH

`define ADDR_ARBITRATION 11'h000
`define ADDR_CAL_CTRL 11'h100
`define ADDR_ID_BYTE0 11'h400
`define ADDR_ID_BYTE1 11'h401
`define ADDR_ID_BYTE2 11'h402
`define ADDR_ID_BYTE3 11'h403
`define ADDR_STATUS_PRESENT 11'h404
`define ADDR_CONTROL_PRESENT 11'h405
`define ADDR_CLKGEN_PRESENT 11'h410
`define ADDR_PLL_STATUS 11'h480
`define ADDR_POWERDOWN 11'h4E0
`define ADDR_STREAM_CTRL 11'h540
`define ADDR_STREAM_STATUS 11'h541

`define BIT_OWNER_SELECT 0
`define BIT_CAL_DONE 1
`define BIT_PREP_REQUEST 0
`define BIT_CAL_ENABLE 1
`define BIT_LOCK 0
`define BIT_CALIBRATING 1
`define BIT_OWNER_FLAG 2
`define BIT_PD_VALUE 0
`define BIT_PD_OVERRIDE 1
`define BIT_STREAM_START 7
`define BIT_STREAM_BUSY 0
`define BIT_PRESENT 0
`define PROFILE_MSB 2

`define RESET_BYTE 8'h00
`define RESET_PROFILE 3'h0
`define ENGINE_OWNS 1'b1
`define USER_OWNS 1'b0

`endif

// file: verilog/frac_pll_reconfig_pkg.sv
// types shared by the pll register bank and its helpers
// assumes frac_pll_reconfig_defines.svh supplies the numbers
package frac_pll_reconfig_pkg;

   typedef enum logic [2:0] {
      ST_IDLE = 3'b001,
      ST_LOAD = 3'b010,
      ST_WAIT = 3'b100
   } stream_state_type;

   typedef struct packed {
      logic write;
      logic read;
      logic [10:0] address;
      logic [7:0] writedata;
   } cfg_request_type;

   typedef struct packed {
      logic start;
      logic [2:0] profile;
   } stream_request_type;

endpackage : frac_pll_reconfig_pkg

// file: verilog/frac_pll_stream_ctrl.sv
// profile streamer sequencer: hands one profile load to the pll and tracks busy
// assumes the pll answers each load with a one-cycle done pulse
`include "frac_pll_reconfig_defines.svh"

module frac_pll_stream_ctrl (
   // clock and reset
   input wire logic clk_i,
   input wire logic resetn_i,
   // request from the register bank
   input frac_pll_reconfig_pkg::stream_request_type request_i,
   // pll streamer side
   output logic load_o,
   output logic [2:0] profile_o,
   input wire logic done_i,
   // status
   output logic busy_o
);

   frac_pll_reconfig_pkg::stream_state_type state;

   always_ff @(posedge clk_i or negedge resetn_i) begin
      if (!resetn_i) begin
         state <= frac_pll_reconfig_pkg::ST_IDLE;
      end else begin
         case (state)
            frac_pll_reconfig_pkg::ST_IDLE: begin
               if (request_i.start) begin
                  state <= frac_pll_reconfig_pkg::ST_LOAD;
               end
            end
            frac_pll_reconfig_pkg::ST_LOAD: begin
               state <= frac_pll_reconfig_pkg::ST_WAIT;
            end
            frac_pll_reconfig_pkg::ST_WAIT: begin
               if (done_i) begin
                  state <= frac_pll_reconfig_pkg::ST_IDLE;
               end
            end
            default: begin
               state <= frac_pll_reconfig_pkg::ST_IDLE;
            end
         endcase
      end
   end

   // profile latched at start so a later select write cannot corrupt a load
   always_ff @(posedge clk_i or negedge resetn_i) begin
      if (!resetn_i) begin
         profile_o <= `RESET_PROFILE;
      end else if (state == frac_pll_reconfig_pkg::ST_IDLE && request_i.start) begin
         profile_o <= request_i.profile;
      end
   end

   always_ff @(posedge clk_i or negedge resetn_i) begin
      if (!resetn_i) begin
         load_o <= 1'b0;
         busy_o <= 1'b0;
      end else begin
         load_o <= (state == frac_pll_reconfig_pkg::ST_IDLE) && request_i.start;
         busy_o <= (state == frac_pll_reconfig_pkg::ST_IDLE) ? request_i.start
                   : !(state == frac_pll_reconfig_pkg::ST_WAIT && done_i);
      end
   end

endmodule : frac_pll_stream_ctrl

// file: verilog/frac_pll_powerdown_mux.sv
// selects the pll power-down source between the normal path and the register value
// assumes all inputs synchronous to clk_i
module frac_pll_powerdown_mux (
   // clock and reset
   input wire logic clk_i,
   input wire logic resetn_i,
   // sources
   input wire logic normal_powerdown_i,
   input wire logic register_value_i,
   input wire logic override_i,
   // pll control
   output logic powerdown_o
);

   always_ff @(posedge clk_i or negedge resetn_i) begin
      if (!resetn_i) begin
         powerdown_o <= 1'b0;
      end else if (override_i) begin
         powerdown_o <= register_value_i;
      end else begin
         powerdown_o <= normal_powerdown_i;
      end
   end

endmodule : frac_pll_powerdown_mux

// file: verilog/frac_pll_reconfig_regs.sv
// register bank for one fractional pll: bus ownership, calibration, status, power-down, streamer
// assumes a byte-wide configuration port on clk_i with one-cycle read latency
`include "frac_pll_reconfig_defines.svh"

module frac_pll_reconfig_regs #(
   parameter logic [31:0] INSTANCE_ID = 32'h0000_0001, // arbitrary value
   parameter bit STATUS_PRESENT = 1'b1,
   parameter bit CONTROL_PRESENT = 1'b1,
   parameter int ADDR_WIDTH = 11
) (
   // clock and reset
   input wire logic clk_i,
   input wire logic resetn_i,
   // configuration port
   input wire logic cfg_write_i,
   input wire logic cfg_read_i,
   input wire logic [ADDR_WIDTH-1:0] cfg_address_i,
   input wire logic [7:0] cfg_writedata_i,
   output logic [7:0] cfg_readdata_o,
   output logic cfg_readvalid_o,
   // pll and calibration engine status
   input wire logic pll_locked_i,
   input wire logic cal_busy_i,
   input wire logic clock_generation_block_enabled_i,
   input wire logic normal_powerdown_i,
   input wire logic stream_done_i,
   // pll and calibration engine control
   output logic bus_owner_engine_o,
   output logic cal_enable_o,
   output logic reconfig_prep_o,
   output logic pll_powerdown_o,
   output logic stream_load_o,
   output logic [2:0] stream_profile_o,
   output logic stream_busy_o
);

   // the decode compares against 11-bit offsets, so no other width is served
   if (ADDR_WIDTH != 11) begin : g_width_check
      $error("ADDR_WIDTH must be 11");
   end

   frac_pll_reconfig_pkg::cfg_request_type req;
   frac_pll_reconfig_pkg::stream_request_type stream_req;
   logic bus_owner_select;
   logic calibration_enable;
   logic reconfig_prep_request;
   logic powerdown_value;
   logic powerdown_override;
   logic [2:0] profile_select;
   logic stream_start;
   logic stream_busy;
   logic [7:0] next_readdata;

   assign req = '{write: cfg_write_i, read: cfg_read_i, address: cfg_address_i,
                  writedata: cfg_writedata_i};

   function automatic logic hit(input frac_pll_reconfig_pkg::cfg_request_type r, input logic [10:0] a);
      hit = r.write && (r.address == a);
   endfunction : hit

   // read strobe aimed at one location; shared by the readback checks
   function automatic logic rd_hit(input frac_pll_reconfig_pkg::cfg_request_type r, input logic [10:0] a);
      rd_hit = r.read && (r.address == a);
   endfunction : rd_hit

   // ownership of the internal configuration bus
   always_ff @(posedge clk_i or negedge resetn_i) begin
      if (!resetn_i) begin
         bus_owner_select <= `USER_OWNS;
      end else if (hit(req, `ADDR_ARBITRATION)) begin
         bus_owner_select <= req.writedata[`BIT_OWNER_SELECT];
      end
   end

   // calibration control
   always_ff @(posedge clk_i or negedge resetn_i) begin
      if (!resetn_i) begin
         calibration_enable <= 1'b0;
         reconfig_prep_request <= 1'b0;
      end else if (hit(req, `ADDR_CAL_CTRL)) begin
         calibration_enable <= req.writedata[`BIT_CAL_ENABLE];
         reconfig_prep_request <= req.writedata[`BIT_PREP_REQUEST];
      end
   end

   // power-down override
   always_ff @(posedge clk_i or negedge resetn_i) begin
      if (!resetn_i) begin
         powerdown_value <= 1'b0;
         powerdown_override <= 1'b0;
      end else if (hit(req, `ADDR_POWERDOWN)) begin
         powerdown_value <= req.writedata[`BIT_PD_VALUE];
         powerdown_override <= req.writedata[`BIT_PD_OVERRIDE];
      end
   end

   // streamer control; start lives one cycle, then the bit clears by itself
   always_ff @(posedge clk_i or negedge resetn_i) begin
      if (!resetn_i) begin
         profile_select <= `RESET_PROFILE;
         stream_start <= 1'b0;
      end else if (hit(req, `ADDR_STREAM_CTRL)) begin
         profile_select <= req.writedata[`PROFILE_MSB:0];
         stream_start <= req.writedata[`BIT_STREAM_START];
      end else begin
         stream_start <= 1'b0;
      end
   end

   // outputs toward the pll and engine, registered
   always_ff @(posedge clk_i or negedge resetn_i) begin
      if (!resetn_i) begin
         bus_owner_engine_o <= `USER_OWNS;
         cal_enable_o <= 1'b0;
         reconfig_prep_o <= 1'b0;
      end else begin
         bus_owner_engine_o <= bus_owner_select;
         cal_enable_o <= calibration_enable;
         reconfig_prep_o <= reconfig_prep_request;
      end
   end

   assign stream_req = '{start: stream_start, profile: profile_select};

   frac_pll_stream_ctrl u_stream (
      .clk_i(clk_i),
      .resetn_i(resetn_i),
      .request_i(stream_req),
      .load_o(stream_load_o),
      .profile_o(stream_profile_o),
      .done_i(stream_done_i),
      .busy_o(stream_busy)
   );

   assign stream_busy_o = stream_busy;

   frac_pll_powerdown_mux u_pd (
      .clk_i(clk_i),
      .resetn_i(resetn_i),
      .normal_powerdown_i(normal_powerdown_i),
      .register_value_i(powerdown_value),
      .override_i(powerdown_override),
      .powerdown_o(pll_powerdown_o)
   );

   // read decode; unmapped locations read zero
   always_comb begin
      next_readdata = `RESET_BYTE;
      if (req.address == `ADDR_ARBITRATION) begin
         next_readdata[`BIT_OWNER_SELECT] = bus_owner_select;
         next_readdata[`BIT_CAL_DONE] = !cal_busy_i;
      end else if (req.address == `ADDR_CAL_CTRL) begin
         next_readdata[`BIT_CAL_ENABLE] = calibration_enable;
         next_readdata[`BIT_PREP_REQUEST] = reconfig_prep_request;
      end else if (req.address == `ADDR_ID_BYTE0) begin
         next_readdata = INSTANCE_ID[7:0];
      end else if (req.address == `ADDR_ID_BYTE1) begin
         next_readdata = INSTANCE_ID[15:8];
      end else if (req.address == `ADDR_ID_BYTE2) begin
         next_readdata = INSTANCE_ID[23:16];
      end else if (req.address == `ADDR_ID_BYTE3) begin
         next_readdata = INSTANCE_ID[31:24];
      end else if (req.address == `ADDR_STATUS_PRESENT) begin
         next_readdata[`BIT_PRESENT] = STATUS_PRESENT;
      end else if (req.address == `ADDR_CONTROL_PRESENT) begin
         next_readdata[`BIT_PRESENT] = CONTROL_PRESENT;
      end else if (req.address == `ADDR_CLKGEN_PRESENT) begin
         next_readdata[`BIT_PRESENT] = clock_generation_block_enabled_i;
      end else if (req.address == `ADDR_PLL_STATUS) begin
         next_readdata[`BIT_LOCK] = pll_locked_i;
         next_readdata[`BIT_CALIBRATING] = cal_busy_i;
         next_readdata[`BIT_OWNER_FLAG] = bus_owner_select;
      end else if (req.address == `ADDR_POWERDOWN) begin
         next_readdata[`BIT_PD_VALUE] = powerdown_value;
         next_readdata[`BIT_PD_OVERRIDE] = powerdown_override;
      end else if (req.address == `ADDR_STREAM_CTRL) begin
         next_readdata[`PROFILE_MSB:0] = profile_select;
         next_readdata[`BIT_STREAM_START] = stream_start;
      end else if (req.address == `ADDR_STREAM_STATUS) begin
         next_readdata[`BIT_STREAM_BUSY] = stream_busy;
      end
   end

   always_ff @(posedge clk_i or negedge resetn_i) begin
      if (!resetn_i) begin
         cfg_readdata_o <= `RESET_BYTE;
         cfg_readvalid_o <= 1'b0;
      end else begin
         cfg_readvalid_o <= req.read;
         if (req.read) begin
            cfg_readdata_o <= next_readdata;
         end
      end
   end

   // assertions
   a_owner_follows_write: assert property (@(posedge clk_i) disable iff (!resetn_i)
      hit(req, `ADDR_ARBITRATION) |-> ##2 bus_owner_engine_o == $past(req.writedata[0], 2))
      else $error("bus owner output does not follow write");
   a_cal_done_inverse: assert property (@(posedge clk_i) disable iff (!resetn_i)
      req.read && req.address == `ADDR_ARBITRATION |=> cfg_readdata_o[1] == !$past(cal_busy_i))
      else $error("calibration done is not inverse of busy");
   a_cal_enable_follows: assert property (@(posedge clk_i) disable iff (!resetn_i)
      hit(req, `ADDR_CAL_CTRL) |-> ##2 cal_enable_o == $past(req.writedata[1], 2))
      else $error("calibration enable does not follow write");
   a_prep_follows: assert property (@(posedge clk_i) disable iff (!resetn_i)
      hit(req, `ADDR_CAL_CTRL) |-> ##2 reconfig_prep_o == $past(req.writedata[0], 2))
      else $error("prep request does not follow write");
   a_id_byte_zero: assert property (@(posedge clk_i) disable iff (!resetn_i)
      req.read && req.address == `ADDR_ID_BYTE0 |=> cfg_readdata_o == INSTANCE_ID[7:0])
      else $error("identifier byte wrong");
   a_lock_readback: assert property (@(posedge clk_i) disable iff (!resetn_i)
      req.read && req.address == `ADDR_PLL_STATUS |=>
      cfg_readdata_o[2:0] == {$past(bus_owner_select), $past(cal_busy_i), $past(pll_locked_i)})
      else $error("pll status readback wrong");
   a_pd_override: assert property (@(posedge clk_i) disable iff (!resetn_i)
      powerdown_override |=> pll_powerdown_o == $past(powerdown_value))
      else $error("override does not select register value");
   a_pd_normal: assert property (@(posedge clk_i) disable iff (!resetn_i)
      !powerdown_override |=> pll_powerdown_o == $past(normal_powerdown_i))
      else $error("register value leaks without override");
   sequence s_start_written;
      hit(req, `ADDR_STREAM_CTRL) && req.writedata[7];
   endsequence
   a_start_self_clears: assert property (@(posedge clk_i) disable iff (!resetn_i)
      s_start_written ##1 !hit(req, `ADDR_STREAM_CTRL) |=> !stream_start)
      else $error("start bit does not clear itself");
   a_busy_after_start: assert property (@(posedge clk_i) disable iff (!resetn_i)
      stream_start && !stream_busy |=> stream_busy && stream_load_o ##1 stream_busy)
      else $error("streaming busy not raised");
   a_profile_taken: assert property (@(posedge clk_i) disable iff (!resetn_i)
      stream_start && !stream_busy |=> stream_profile_o == $past(profile_select))
      else $error("wrong profile loaded");
   a_read_answer: assert property (@(posedge clk_i) disable iff (!resetn_i)
      req.read |=> cfg_readvalid_o)
      else $error("read answer missing");
   a_id_byte_three: assert property (@(posedge clk_i) disable iff (!resetn_i)
      rd_hit(req, `ADDR_ID_BYTE3) |=> cfg_readdata_o == INSTANCE_ID[31:24])
      else $error("identifier top byte wrong");
   a_status_present: assert property (@(posedge clk_i) disable iff (!resetn_i)
      rd_hit(req, `ADDR_STATUS_PRESENT) |=> cfg_readdata_o == {7'h00, STATUS_PRESENT})
      else $error("status presence flag wrong");
   a_control_present: assert property (@(posedge clk_i) disable iff (!resetn_i)
      rd_hit(req, `ADDR_CONTROL_PRESENT) |=> cfg_readdata_o == {7'h00, CONTROL_PRESENT})
      else $error("control presence flag wrong");
   a_clkgen_readback: assert property (@(posedge clk_i) disable iff (!resetn_i)
      rd_hit(req, `ADDR_CLKGEN_PRESENT) |=> cfg_readdata_o == {7'h00, $past(clock_generation_block_enabled_i)})
      else $error("clock generation flag wrong");
   a_owner_readback: assert property (@(posedge clk_i) disable iff (!resetn_i)
      rd_hit(req, `ADDR_ARBITRATION) |=> cfg_readdata_o[`BIT_OWNER_SELECT] == $past(bus_owner_select))
      else $error("owner select readback wrong");
   a_cal_ctrl_readback: assert property (@(posedge clk_i) disable iff (!resetn_i)
      rd_hit(req, `ADDR_CAL_CTRL) |=>
      cfg_readdata_o[1:0] == {$past(calibration_enable), $past(reconfig_prep_request)})
      else $error("calibration control readback wrong");
   a_pd_write_taken: assert property (@(posedge clk_i) disable iff (!resetn_i)
      hit(req, `ADDR_POWERDOWN) |=> powerdown_override == $past(req.writedata[`BIT_PD_OVERRIDE]))
      else $error("override bit not stored");
   a_profile_stored: assert property (@(posedge clk_i) disable iff (!resetn_i)
      hit(req, `ADDR_STREAM_CTRL) |=> profile_select == $past(req.writedata[`PROFILE_MSB:0]))
      else $error("profile select not stored");
   // a start that lands while a load is under way must not launch another one
   a_start_refused_busy: assert property (@(posedge clk_i) disable iff (!resetn_i)
      stream_start && stream_busy |=> !stream_load_o)
      else $error("start accepted while busy");
   // busy without the load pulse means the sequencer is waiting for done
   sequence s_wait_done;
      stream_busy && !stream_load_o && stream_done_i;
   endsequence
   sequence s_wait_idle;
      stream_busy && !stream_load_o && !stream_done_i;
   endsequence
   a_busy_clears_done: assert property (@(posedge clk_i) disable iff (!resetn_i)
      s_wait_done |=> !stream_busy)
      else $error("busy did not clear after done");
   a_busy_holds_wait: assert property (@(posedge clk_i) disable iff (!resetn_i)
      s_wait_idle |=> stream_busy)
      else $error("busy dropped before done");

endmodule : frac_pll_reconfig_regs

// file: testbench/test_frac_pll_reconfig_regs.sv
// testbench for frac_pll_reconfig_regs: ownership, calibration, identity, status, power-down, streamer
// assumes the design files under verilog/ and the defines header on the include path
`include "frac_pll_reconfig_defines.svh"

module test_frac_pll_reconfig_regs;
   timeunit 1ns;
   timeprecision 100ps;

   localparam logic [31:0] ID = 32'hA5C3_1E69; // arbitrary value

   logic clk_i = 1'b0;
   logic resetn_i = 1'b0;
   logic cfg_write_i = 1'b0;
   logic cfg_read_i = 1'b0;
   logic [10:0] cfg_address_i = 11'h000;
   logic [7:0] cfg_writedata_i = 8'h00;
   logic [7:0] cfg_readdata_o;
   logic cfg_readvalid_o;
   logic pll_locked_i = 1'b0;
   logic cal_busy_i = 1'b0;
   logic clock_generation_block_enabled_i = 1'b0;
   logic normal_powerdown_i = 1'b0;
   logic stream_done_i = 1'b0;
   logic bus_owner_engine_o, cal_enable_o, reconfig_prep_o, pll_powerdown_o;
   logic stream_load_o, stream_busy_o;
   logic [2:0] stream_profile_o;
   int err_count = 0;
   int n_compared = 0;
   int cycles = 0;
   int loads = 0;
   int n;

   always #25 clk_i = ~clk_i;

   frac_pll_reconfig_regs #(.INSTANCE_ID(ID), .STATUS_PRESENT(1'b1), .CONTROL_PRESENT(1'b0)) DUT (
      .clk_i(clk_i), .resetn_i(resetn_i),
      .cfg_write_i(cfg_write_i), .cfg_read_i(cfg_read_i), .cfg_address_i(cfg_address_i),
      .cfg_writedata_i(cfg_writedata_i), .cfg_readdata_o(cfg_readdata_o), .cfg_readvalid_o(cfg_readvalid_o),
      .pll_locked_i(pll_locked_i), .cal_busy_i(cal_busy_i),
      .clock_generation_block_enabled_i(clock_generation_block_enabled_i),
      .normal_powerdown_i(normal_powerdown_i), .stream_done_i(stream_done_i),
      .bus_owner_engine_o(bus_owner_engine_o), .cal_enable_o(cal_enable_o), .reconfig_prep_o(reconfig_prep_o),
      .pll_powerdown_o(pll_powerdown_o), .stream_load_o(stream_load_o),
      .stream_profile_o(stream_profile_o), .stream_busy_o(stream_busy_o)
   );

   task tally_and_finish();
      if (err_count == 0 && n_compared > 0) begin
         $display("bench passed");
      end else begin
         $display("bench failed");
      end
      $finish;
   endtask : tally_and_finish

   // counts load pulses so a refused start shows up as a missing increment
   always @(posedge clk_i) begin
      cycles++;
      if (stream_load_o === 1'b1) begin
         loads++;
      end
      if (cycles == 20000) begin
         err_count++;
         tally_and_finish();
      end
   end

   task chk(input logic [31:0] seen, input logic [31:0] exp);
      n_compared++;
      if (seen !== exp) begin
         err_count++;
         $display("Error at %0t: seen %0h expected %0h", $time, seen, exp);
      end
   endtask : chk

   // inputs always move 5 ns after the rising edge, away from sampling
   task step(input int k);
      repeat (k) begin
         @(posedge clk_i);
         #5;
      end
   endtask : step

   task wr(input logic [10:0] a, input logic [7:0] v);
      cfg_write_i = 1'b1;
      cfg_address_i = a;
      cfg_writedata_i = v;
      step(1);
      cfg_write_i = 1'b0;
   endtask : wr

   task rdchk(input logic [10:0] a, input logic [7:0] mask, input logic [7:0] exp);
      int k;
      cfg_read_i = 1'b1;
      cfg_address_i = a;
      step(1);
      cfg_read_i = 1'b0;
      k = 0;
      while (cfg_readvalid_o !== 1'b1 && k < 4) begin
         step(1);
         k++;
      end
      chk(cfg_readvalid_o, 1'b1);
      chk(cfg_readdata_o & mask, exp);
      // one idle edge so a following read never re-raises the strobe in the same step
      step(1);
   endtask : rdchk

   initial begin
      step(3);
      resetn_i = 1'b1;
      chk({bus_owner_engine_o, cal_enable_o, reconfig_prep_o, stream_load_o, stream_busy_o}, 5'h00);
      // engine phase touches only arbitration and status places
      for (int o = 0; o < 2; o++) begin
         wr(`ADDR_ARBITRATION, {7'h00, ~o[0]});
         step(1);
         chk(bus_owner_engine_o, {~o[0]});
         rdchk(`ADDR_PLL_STATUS, 8'h04, {5'h00, ~o[0], 2'b00});
         rdchk(`ADDR_ARBITRATION, 8'h01, {7'h00, ~o[0]});
      end
      wr(`ADDR_ARBITRATION, 8'h02);
      for (int b = 0; b < 2; b++) begin
         cal_busy_i = b[0];
         step(1);
         rdchk(`ADDR_ARBITRATION, 8'h02, {6'h00, ~b[0], 1'b0});
      end
      cal_busy_i = 1'b0;
      for (int i = 0; i < 4; i++) begin
         wr(`ADDR_CAL_CTRL, {6'h00, i[1:0]});
         step(1);
         chk({cal_enable_o, reconfig_prep_o}, i[1:0]);
         rdchk(`ADDR_CAL_CTRL, 8'h03, {6'h00, i[1:0]});
      end
      wr(`ADDR_ID_BYTE0, 8'hFF);
      for (int i = 0; i < 4; i++) begin
         rdchk(`ADDR_ID_BYTE0 + 11'(i), 8'hFF, ID[8*i+:8]);
      end
      rdchk(`ADDR_STATUS_PRESENT, 8'h01, 8'h01);
      rdchk(`ADDR_CONTROL_PRESENT, 8'h01, 8'h00);
      for (int i = 0; i < 2; i++) begin
         clock_generation_block_enabled_i = i[0];
         step(1);
         rdchk(`ADDR_CLKGEN_PRESENT, 8'h01, {7'h00, i[0]});
      end
      for (int i = 0; i < 4; i++) begin
         {cal_busy_i, pll_locked_i} = i[1:0];
         step(1);
         rdchk(`ADDR_PLL_STATUS, 8'h07, {6'h00, i[1:0]});
      end
      {cal_busy_i, pll_locked_i} = 2'b00;
      wr(`ADDR_PLL_STATUS, 8'hFF);
      rdchk(`ADDR_PLL_STATUS, 8'h07, 8'h00);
      rdchk(11'h7FF, 8'hFF, 8'h00);
      for (int i = 0; i < 8; i++) begin
         normal_powerdown_i = i[2];
         wr(`ADDR_POWERDOWN, {6'h00, i[1], i[0]});
         step(1);
         chk(pll_powerdown_o, i[1] ? i[0] : i[2]);
         rdchk(`ADDR_POWERDOWN, 8'h03, {6'h00, i[1:0]});
      end
      normal_powerdown_i = 1'b0;
      step(2);
      chk(pll_powerdown_o, 1'b1);
      wr(`ADDR_POWERDOWN, 8'h00);
      step(2);
      chk(pll_powerdown_o, 1'b0);
      for (int p = 0; p < 8; p++) begin
         n = loads;
         wr(`ADDR_STREAM_CTRL, {5'h10, p[2:0]});
         step(1);
         chk({stream_load_o, stream_busy_o, stream_profile_o}, {2'b11, p[2:0]});
         rdchk(`ADDR_STREAM_CTRL, 8'h87, {5'h00, p[2:0]});
         wr(`ADDR_STREAM_CTRL, {5'h10, ~p[2:0]});
         step(2);
         chk(loads, n + 1);
         chk(stream_profile_o, p[2:0]);
         rdchk(`ADDR_STREAM_STATUS, 8'h01, 8'h01);
         rdchk(`ADDR_STREAM_CTRL, 8'h80, 8'h00);
         stream_done_i = 1'b1;
         step(1);
         stream_done_i = 1'b0;
         chk(stream_busy_o, 1'b0);
         rdchk(`ADDR_STREAM_STATUS, 8'h01, 8'h00);
      end
      // second reset in mid-run must clear control state again
      wr(`ADDR_CAL_CTRL, 8'h03);
      step(1);
      resetn_i = 1'b0;
      step(1);
      resetn_i = 1'b1;
      chk({cal_enable_o, reconfig_prep_o, bus_owner_engine_o}, 3'h0);
      rdchk(`ADDR_CAL_CTRL, 8'h03, 8'h00);
      tally_and_finish();
   end
endmodule : test_frac_pll_reconfig_regs
